// ==== rtl/tls_analog_cond.sv ====
// tls_analog_cond: offset correction and first-order lag of one analog limit input
`timescale 1ns/1ps
`default_nettype none
module tls_analog_cond (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        tick,
  input  wire logic [15:0] sampleMv,
  input  wire logic [15:0] offsetMv,
  input  wire logic [3:0]  tcShift,
  output logic      [15:0] filtMv
);
  import tls_pkg::*;

  logic signed [16:0] corr;
  logic signed [15:0] corrSat;
  logic signed [24:0] diff;
  logic signed [24:0] step;
  logic signed [23:0] acc_q;

  always_comb begin
    corr    = $signed({sampleMv[15], sampleMv}) - $signed({offsetMv[15], offsetMv});
    corrSat = corr[15:0];
    if (corr > 17'sh07fff) corrSat = 16'sh7fff;
    if (corr < -17'sh08000) corrSat = -16'sh8000;
    diff    = $signed({corrSat[15], corrSat, 8'h00}) - $signed({acc_q[23], acc_q});
    step    = diff >>> tcShift;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_q <= 24'sh000000;
    end else if (tick) begin
      acc_q <= 24'($signed({acc_q[23], acc_q}) + step);
    end
  end

  assign filtMv = acc_q[23:FILT_FRAC];
endmodule // tls_analog_cond
`default_nettype wire

// ==== rtl/tls_limit_ramp.sv ====
// tls_limit_ramp: rate-limited walk of the switched limit toward its target
`timescale 1ns/1ps
`default_nettype none
module tls_limit_ramp (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        tick,
  input  wire logic        jump,
  input  wire logic        rising,
  input  wire logic [11:0] target,
  input  wire logic [11:0] rate,
  output logic      [11:0] value_q
);
  import tls_pkg::*;

  logic [12:0] up;
  logic [11:0] dn;

  always_comb begin
    up = {1'b0, value_q} + {1'b0, rate};
    dn = (value_q > rate) ? value_q - rate : 12'h000;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      value_q <= LIMIT_FULL;
    end else if (jump || rate == 12'h000) begin
      value_q <= target;
    end else if (tick && value_q != target) begin
      if (rising) begin
        value_q <= (value_q > target || up > {1'b0, target}) ? target : up[11:0];
      end else begin
        value_q <= (value_q < target || dn < target) ? target : dn;
      end
    end
  end
endmodule // tls_limit_ramp
`default_nettype wire

// ==== rtl/tls_pkg.sv ====
// tls_pkg: constants and types of the torque limit selector
//
// Contract
// - source 0: forward from forward analog 0..10 V, reverse from reverse analog -10..0 V
// - source 1: first stored limit bounds both directions
// - source 2: forward by first stored limit, reverse by second
// - source 3: set select off gives first limit, on gives second, both directions
// - source 4: forward and reverse analog inputs, both over 0..10 V
// - source 5: forward analog input 0..10 V bounds both directions
// - source 6: select off gives first/second, on gives network forward/reverse
// - with feed-forward, limit applies only in speed control with source 1..3
// - ramped switching only for source 3, otherwise limit changes at once
// - first-to-second rate going to second, second-to-first rate going back
// - ramp direction follows comparison of first and second stored magnitudes
// - rewriting a stored limit skips the ramp, new value applies at once
// - limits range 0..300.0 percent, default 300.0, lower settable maximum
// - analog limit equals analog input times programmable gain
// - programmable offset removed from each analog input first
// - each analog input passes a programmable first-order lag filter
package tls_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          CTRL_CYCLE_NS   = 10000;
  localparam int          CTRL_CYCLE_CLKS = CTRL_CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [9:0]  TICK_LAST       = 10'(CTRL_CYCLE_CLKS - 1);
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_FIRST       = 8'h04;
  localparam logic [7:0]  REG_SECOND      = 8'h08;
  localparam logic [7:0]  REG_RATE12      = 8'h0c;
  localparam logic [7:0]  REG_RATE21      = 8'h10;
  localparam logic [7:0]  REG_NET_FWD     = 8'h14;
  localparam logic [7:0]  REG_NET_REV     = 8'h18;
  localparam logic [7:0]  REG_GAIN        = 8'h1c;
  localparam logic [7:0]  REG_A2_OFFSET   = 8'h20;
  localparam logic [7:0]  REG_A2_TC       = 8'h24;
  localparam logic [7:0]  REG_A3_OFFSET   = 8'h28;
  localparam logic [7:0]  REG_A3_TC       = 8'h2c;
  localparam logic [7:0]  REG_MAX_LIMIT   = 8'h30;
  localparam logic [7:0]  REG_STATUS      = 8'h34;
  localparam logic [7:0]  REG_TORQUE      = 8'h38;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int          CTRL_SEL_LSB    = 0;
  localparam int          CTRL_MODE_LSB   = 3;
  localparam int          CTRL_FF_BIT     = 5;
  localparam int          STAT_REV_LSB    = 16;
  localparam int          STAT_SET_BIT    = 28;
  localparam int          STAT_RAMP_BIT   = 29;
  localparam int          GAIN_SHIFT      = 12;
  localparam int          FILT_FRAC       = 8;
  localparam logic [11:0] LIMIT_FULL      = 12'hbb8;
  localparam logic [15:0] GAIN_RESET      = 16'h04cd;
  localparam logic [11:0] RATE_RESET      = 12'h000;
  localparam logic [3:0]  TC_RESET        = 4'h0;
  localparam logic [2:0]  SEL_RESET       = 3'h1;
  // ---------------------------------------------------------------
  // limit sources and control modes
  // ---------------------------------------------------------------
  localparam logic [2:0]  SRC_ANALOG_SPLIT  = 3'h0;
  localparam logic [2:0]  SRC_FIRST_BOTH    = 3'h1;
  localparam logic [2:0]  SRC_FIRST_SECOND  = 3'h2;
  localparam logic [2:0]  SRC_SWITCHED      = 3'h3;
  localparam logic [2:0]  SRC_ANALOG_POS    = 3'h4;
  localparam logic [2:0]  SRC_ANALOG_SHARED = 3'h5;
  localparam logic [2:0]  SRC_NETWORK       = 3'h6;
  localparam logic [1:0]  MODE_POSITION     = 2'h0;
  localparam logic [1:0]  MODE_SPEED        = 2'h1;
  localparam logic [1:0]  MODE_TORQUE       = 2'h2;
  localparam logic [1:0]  MODE_FULL_CLOSED  = 2'h3;

  typedef struct packed {
    logic [11:0] fwd;
    logic [11:0] rev;
  } tlsLimitPair_t;
endpackage

// ==== rtl/tls_torque_limit.sv ====
// tls_torque_limit: torque limit source selection, ramp and command clamp
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tls_torque_limit (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [15:0]           forwardLimitAnalogIn,
  input  wire logic [15:0]           reverseLimitAnalogIn,
  input  wire logic                  limitSetSelectIn,
  input  wire logic [15:0]           torqueCmdIn,
  output logic      [15:0]           torqueCmdLimited,
  output tls_pkg::tlsLimitPair_t     activeLimit
);
  import tls_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0]    limitSourceSelect_q;
  logic [1:0]    ctrlMode_q;
  logic          feedFwdEn_q;
  logic [11:0]   firstStoredLimit_q;
  logic [11:0]   secondStoredLimit_q;
  logic [11:0]   rampRateFirstToSecond_q;
  logic [11:0]   rampRateSecondToFirst_q;
  logic [11:0]   networkForwardLimit_q;
  logic [11:0]   networkReverseLimit_q;
  logic [15:0]   analogLimitGain_q;
  logic [15:0]   analogTwoOffset_q;
  logic [3:0]    analogTwoFilterTc_q;
  logic [15:0]   analogThreeOffset_q;
  logic [3:0]    analogThreeFilterTc_q;
  logic [11:0]   maxLimit_q;
  logic [31:0]   prdata_q;
  logic          jump_q;
  logic [9:0]    tickCnt_q;
  logic          setSync1_q;
  logic          setSync2_q;
  logic          setSync3_q;
  logic          setOn_q;
  tlsLimitPair_t limit_q;
  logic [15:0]   torque_q;

  logic          tick;
  logic          hit;
  logic          wrEn;
  logic [11:0]   wrLimit;
  logic [31:0]   rdMux;
  logic [15:0]   fwdMv;
  logic [15:0]   revMv;
  logic [11:0]   rampTarget;
  logic [11:0]   rampRate;
  logic          rampRising;
  logic          rampJump;
  logic [11:0]   rampValue;
  tlsLimitPair_t srcPair;
  tlsLimitPair_t capPair;
  logic signed [15:0] fwdS;
  logic signed [15:0] revS;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // gain conversion
  function automatic logic [11:0] toLimit(input logic [15:0] mv, input logic [15:0] g);
    logic [31:0] prod;
    prod = 32'h0;
    if (!mv[15]) prod = {16'h0, mv} * {16'h0, g};
    prod = prod >> GAIN_SHIFT;
    toLimit = (prod > {20'h0, LIMIT_FULL}) ? LIMIT_FULL : prod[11:0];
  endfunction
  function automatic logic [11:0] capMax(input logic [11:0] v, input logic [11:0] m);
    capMax = (v > m) ? m : v;
  endfunction

  // ---------------------------------------------------------------
  // control cycle tick
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tickCnt_q <= 10'h000;
    end else begin
      tickCnt_q <= (tickCnt_q == TICK_LAST) ? 10'h000 : tickCnt_q + 10'h001;
    end
  end
  assign tick = (tickCnt_q == TICK_LAST);

  // ---------------------------------------------------------------
  // limit set select pin
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      setSync1_q <= 1'b0;
      setSync2_q <= 1'b0;
      setSync3_q <= 1'b0;
      setOn_q    <= 1'b0;
    end else begin
      setSync1_q <= limitSetSelectIn;
      setSync2_q <= setSync1_q;
      setSync3_q <= setSync2_q;
      if (setSync2_q == setSync3_q) setOn_q <= setSync3_q;
    end
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  always_comb begin
    hit = (paddr[1:0] == 2'h0) && (paddr <= REG_TORQUE);
    wrEn = psel && penable && pwrite && hit;
    wrLimit = (pwdata > {20'h0, LIMIT_FULL}) ? LIMIT_FULL : pwdata[11:0];
    rdMux = 32'h0;
    case (paddr)
      REG_CTRL: begin
        rdMux[CTRL_SEL_LSB +: 3]  = limitSourceSelect_q;
        rdMux[CTRL_MODE_LSB +: 2] = ctrlMode_q;
        rdMux[CTRL_FF_BIT]        = feedFwdEn_q;
      end
      REG_FIRST:     rdMux[11:0] = firstStoredLimit_q;
      REG_SECOND:    rdMux[11:0] = secondStoredLimit_q;
      REG_RATE12:    rdMux[11:0] = rampRateFirstToSecond_q;
      REG_RATE21:    rdMux[11:0] = rampRateSecondToFirst_q;
      REG_NET_FWD:   rdMux[11:0] = networkForwardLimit_q;
      REG_NET_REV:   rdMux[11:0] = networkReverseLimit_q;
      REG_GAIN:      rdMux[15:0] = analogLimitGain_q;
      REG_A2_OFFSET: rdMux[15:0] = analogTwoOffset_q;
      REG_A2_TC:     rdMux[3:0]  = analogTwoFilterTc_q;
      REG_A3_OFFSET: rdMux[15:0] = analogThreeOffset_q;
      REG_A3_TC:     rdMux[3:0]  = analogThreeFilterTc_q;
      REG_MAX_LIMIT: rdMux[11:0] = maxLimit_q;
      REG_STATUS: begin
        rdMux[11:0]                = limit_q.fwd;
        rdMux[STAT_REV_LSB +: 12]  = limit_q.rev;
        rdMux[STAT_SET_BIT]        = setOn_q;
        rdMux[STAT_RAMP_BIT]       = (rampValue != rampTarget);
      end
      REG_TORQUE:    rdMux[15:0] = torque_q;
      default:       rdMux = 32'h0;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= hit ? rdMux : 32'h0;
    end
  end
  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      limitSourceSelect_q     <= SEL_RESET;
      ctrlMode_q              <= MODE_POSITION;
      feedFwdEn_q             <= 1'b0;
      firstStoredLimit_q      <= LIMIT_FULL;
      secondStoredLimit_q     <= LIMIT_FULL;
      rampRateFirstToSecond_q <= RATE_RESET;
      rampRateSecondToFirst_q <= RATE_RESET;
      networkForwardLimit_q   <= LIMIT_FULL;
      networkReverseLimit_q   <= LIMIT_FULL;
      analogLimitGain_q       <= GAIN_RESET;
      analogTwoOffset_q       <= 16'h0000;
      analogTwoFilterTc_q     <= TC_RESET;
      analogThreeOffset_q     <= 16'h0000;
      analogThreeFilterTc_q   <= TC_RESET;
      maxLimit_q              <= LIMIT_FULL;
    end else if (wrEn) begin
      case (paddr)
        REG_CTRL: begin
          limitSourceSelect_q <= pwdata[CTRL_SEL_LSB +: 3];
          ctrlMode_q          <= pwdata[CTRL_MODE_LSB +: 2];
          feedFwdEn_q         <= pwdata[CTRL_FF_BIT];
        end
        REG_FIRST:     firstStoredLimit_q      <= wrLimit;
        REG_SECOND:    secondStoredLimit_q     <= wrLimit;
        REG_RATE12:    rampRateFirstToSecond_q <= pwdata[11:0];
        REG_RATE21:    rampRateSecondToFirst_q <= pwdata[11:0];
        REG_NET_FWD:   networkForwardLimit_q   <= wrLimit;
        REG_NET_REV:   networkReverseLimit_q   <= wrLimit;
        REG_GAIN:      analogLimitGain_q       <= pwdata[15:0];
        REG_A2_OFFSET: analogTwoOffset_q       <= pwdata[15:0];
        REG_A2_TC:     analogTwoFilterTc_q     <= pwdata[3:0];
        REG_A3_OFFSET: analogThreeOffset_q     <= pwdata[15:0];
        REG_A3_TC:     analogThreeFilterTc_q   <= pwdata[3:0];
        REG_MAX_LIMIT: maxLimit_q              <= wrLimit;
        default:       maxLimit_q              <= maxLimit_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      jump_q <= 1'b0;
    end else begin
      jump_q <= wrEn && (paddr == REG_FIRST || paddr == REG_SECOND);
    end
  end

  // ---------------------------------------------------------------
  // analog inputs and ramp
  // ---------------------------------------------------------------
  tls_analog_cond u_condFwd (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .tick     (tick),
    .sampleMv (forwardLimitAnalogIn),
    .offsetMv (analogTwoOffset_q),
    .tcShift  (analogTwoFilterTc_q),
    .filtMv   (fwdMv)
  );
  tls_analog_cond u_condRev (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .tick     (tick),
    .sampleMv (reverseLimitAnalogIn),
    .offsetMv (analogThreeOffset_q),
    .tcShift  (analogThreeFilterTc_q),
    .filtMv   (revMv)
  );

  always_comb begin
    rampTarget = setOn_q ? secondStoredLimit_q : firstStoredLimit_q;
    rampRate   = setOn_q ? rampRateFirstToSecond_q : rampRateSecondToFirst_q;
    rampRising = setOn_q ? (secondStoredLimit_q > firstStoredLimit_q)
                         : (firstStoredLimit_q > secondStoredLimit_q);
    rampJump   = jump_q || (limitSourceSelect_q != SRC_SWITCHED);
  end

  tls_limit_ramp u_ramp (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tick    (tick),
    .jump    (rampJump),
    .rising  (rampRising),
    .target  (rampTarget),
    .rate    (rampRate),
    .value_q (rampValue)
  );

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  always_comb begin
    srcPair = '{fwd: firstStoredLimit_q, rev: firstStoredLimit_q};
    case (limitSourceSelect_q)
      SRC_ANALOG_SPLIT:  srcPair = '{fwd: toLimit(fwdMv, analogLimitGain_q),
                                     rev: toLimit(16'(-revMv), analogLimitGain_q)};
      SRC_FIRST_BOTH:    srcPair = '{fwd: firstStoredLimit_q, rev: firstStoredLimit_q};
      SRC_FIRST_SECOND:  srcPair = '{fwd: firstStoredLimit_q, rev: secondStoredLimit_q};
      SRC_SWITCHED:      srcPair = '{fwd: rampValue, rev: rampValue};
      SRC_ANALOG_POS:    srcPair = '{fwd: toLimit(fwdMv, analogLimitGain_q),
                                     rev: toLimit(revMv, analogLimitGain_q)};
      SRC_ANALOG_SHARED: srcPair = '{fwd: toLimit(fwdMv, analogLimitGain_q),
                                     rev: toLimit(fwdMv, analogLimitGain_q)};
      SRC_NETWORK:       srcPair = setOn_q ?
                           '{fwd: networkForwardLimit_q, rev: networkReverseLimit_q} :
                           '{fwd: firstStoredLimit_q, rev: secondStoredLimit_q};
      default:           srcPair = '{fwd: firstStoredLimit_q, rev: firstStoredLimit_q};
    endcase
    if (feedFwdEn_q && !(ctrlMode_q == MODE_SPEED &&
        limitSourceSelect_q >= SRC_FIRST_BOTH && limitSourceSelect_q <= SRC_SWITCHED)) begin
      srcPair = '{fwd: LIMIT_FULL, rev: LIMIT_FULL};
    end
    capPair = '{fwd: capMax(srcPair.fwd, maxLimit_q), rev: capMax(srcPair.rev, maxLimit_q)};
    fwdS = $signed({4'h0, capPair.fwd});
    revS = -$signed({4'h0, capPair.rev});
  end

  // ---------------------------------------------------------------
  // command clamp
  // ---------------------------------------------------------------
  // clamp per cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      limit_q  <= '{fwd: 12'h000, rev: 12'h000};
      torque_q <= 16'h0000;
    end else if (tick) begin
      limit_q <= capPair;
      if ($signed(torqueCmdIn) > fwdS) begin
        torque_q <= fwdS;
      end else if ($signed(torqueCmdIn) < revS) begin
        torque_q <= revS;
      end else begin
        torque_q <= torqueCmdIn;
      end
    end
  end

  assign torqueCmdLimited = torque_q;
  assign activeLimit      = limit_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cbSys @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_firstBoth;
    (tick && limitSourceSelect_q == SRC_FIRST_BOTH && !feedFwdEn_q)
      |=> limit_q.fwd == ($past(firstStoredLimit_q) < $past(maxLimit_q) ?
          $past(firstStoredLimit_q) : $past(maxLimit_q)) && limit_q.rev == limit_q.fwd;
  endproperty
  a_firstBoth: assert property (p_firstBoth) else $error("first limit not on both");
  property p_firstSecond;
    (tick && limitSourceSelect_q == SRC_FIRST_SECOND && !feedFwdEn_q)
      |=> limit_q.rev == ($past(secondStoredLimit_q) < $past(maxLimit_q) ?
          $past(secondStoredLimit_q) : $past(maxLimit_q));
  endproperty
  a_firstSecond: assert property (p_firstSecond) else $error("reverse not second");
  property p_switchedSame;
    (tick && limitSourceSelect_q == SRC_SWITCHED) |=> limit_q.fwd == limit_q.rev;
  endproperty
  a_switchedSame: assert property (p_switchedSame) else $error("switched limits differ");
  property p_sharedAnalog;
    (tick && limitSourceSelect_q == SRC_ANALOG_SHARED) |=> limit_q.fwd == limit_q.rev;
  endproperty
  a_sharedAnalog: assert property (p_sharedAnalog) else $error("shared analog differs");
  property p_ffGate;
    (tick && feedFwdEn_q && ctrlMode_q != MODE_SPEED)
      |=> limit_q.fwd == $past(maxLimit_q) && limit_q.rev == $past(maxLimit_q);
  endproperty
  a_ffGate: assert property (p_ffGate) else $error("limit applied outside speed");
  property p_noRamp;
    (limitSourceSelect_q != SRC_SWITCHED) |=> rampValue == $past(rampTarget);
  endproperty
  a_noRamp: assert property (p_noRamp) else $error("ramp outside switched source");
  property p_rewriteJump;
    jump_q |=> rampValue == $past(rampTarget);
  endproperty
  a_rewriteJump: assert property (p_rewriteJump) else $error("rewrite was ramped");
  property p_maxCap;
    tick |=> limit_q.fwd <= $past(maxLimit_q) && limit_q.rev <= $past(maxLimit_q);
  endproperty
  a_maxCap: assert property (p_maxCap) else $error("limit above maximum");
  property p_clamp;
    tick |=> $signed(torque_q) <= $signed({4'h0, limit_q.fwd}) &&
             $signed(torque_q) >= -$signed({4'h0, limit_q.rev});
  endproperty
  a_clamp: assert property (p_clamp) else $error("torque outside limits");
  c_ramping: cover property (limitSourceSelect_q == SRC_SWITCHED && rampValue != rampTarget);
  c_clampFwd: cover property (tick && $signed(torqueCmdIn) > fwdS);
  c_netSet: cover property (tick && limitSourceSelect_q == SRC_NETWORK && setOn_q);
  c_analogSplit: cover property (tick && limitSourceSelect_q == SRC_ANALOG_SPLIT);
endmodule // tls_torque_limit
`default_nettype wire

// ==== tb/tb.sv ====
// tb: random and corner stimulus for the torque limit selector
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tls_pkg::*;
  logic          clk_sys = 0, reset = 1, psel = 0, penable = 0;
  logic          pwrite = 0, selSet = 0, pready, pslverr, er, selPin;
  logic [7:0]    paddr = '0;
  logic [31:0]   pwdata = '0, prdata, rd;
  logic [15:0]   fwdSet = '0, revSet = '0, fwdMv, revMv, cmd = '0, cmdOut, c, ma, mb;
  logic [11:0]   fl, sl, nf, nr;
  tlsLimitPair_t lim, ex;
  int            n_errors = 0, check_count = 0, seed = 32'h8a7450b4, s;
  tls_torque_limit tls_torque_limit_i (.clk_sys, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .forwardLimitAnalogIn(fwdMv),
    .reverseLimitAnalogIn(revMv), .limitSetSelectIn(selPin), .torqueCmdIn(cmd),
    .torqueCmdLimited(cmdOut), .activeLimit(lim));
  tls_far_side tls_far_side_i (.clk_sys, .fwdSet, .revSet, .selSet, .fwdMv, .revMv,
    .selPin);
  initial forever #5 clk_sys = ~clk_sys;
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  function automatic logic [11:0] al(logic [15:0] mv);
    return (mv > 3000) ? 12'hbb8 : mv[11:0];
  endfunction
  function automatic logic [11:0] rnd(int m);
    return 12'($unsigned($random(seed)) % m);
  endfunction
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys);
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    apb(0, REG_FIRST, 0);
    chk("first", rd, 32'hbb8);
    apb(0, 8'h3c, 0);
    chk("unmapped", {31'h0, er}, 32'h1);
    apb(1, REG_SECOND, 32'hfa0);
    apb(0, REG_SECOND, 0);
    chk("satur", rd, 32'hbb8);
    apb(1, REG_GAIN, 32'h1000);
    for (int i = 0; i < 14; i++) begin
      s = i >> 1;
      fl = rnd(3001); sl = rnd(3001); nf = rnd(3001); nr = rnd(3001);
      ma = 16'(rnd(4000)); mb = 16'(rnd(4000));
      fwdSet <= ma;
      revSet <= (s == 0) ? -mb : mb;
      selSet <= i[0];
      cmd <= 16'($random(seed));
      apb(1, REG_FIRST, {20'h0, fl});
      apb(1, REG_SECOND, {20'h0, sl});
      apb(1, REG_NET_FWD, {20'h0, nf});
      apb(1, REG_NET_REV, {20'h0, nr});
      apb(1, REG_CTRL, 32'(s));
      repeat (3000) @(posedge clk_sys);
      case (s)
        0, 4: ex = '{al(ma), al(mb)};
        1: ex = '{fl, fl};
        2: ex = '{fl, sl};
        3: ex = i[0] ? '{sl, sl} : '{fl, fl};
        5: ex = '{al(ma), al(ma)};
        default: ex = i[0] ? '{nf, nr} : '{fl, sl};
      endcase
      chk("limit", {8'h0, lim}, {8'h0, ex});
      c = ($signed(cmd) > $signed({4'h0, ex.fwd})) ? {4'h0, ex.fwd} : cmd;
      c = ($signed(cmd) < -$signed({4'h0, ex.rev})) ? -{4'h0, ex.rev} : c;
      chk("clamp", {16'h0, cmdOut}, {16'h0, c});
    end
    apb(1, REG_MAX_LIMIT, 32'd2000);
    apb(1, REG_FIRST, 32'd2500);
    apb(1, REG_SECOND, 32'd1200);
    apb(1, REG_CTRL, 32'h22);
    repeat (2100) @(posedge clk_sys);
    chk("ffpos", {8'h0, lim}, {8'h0, 12'd2000, 12'd2000});
    apb(1, REG_CTRL, 32'h2a);
    repeat (2100) @(posedge clk_sys);
    chk("ffspd", {8'h0, lim}, {8'h0, 12'd2000, 12'd1200});
    apb(1, REG_MAX_LIMIT, 32'd3000);
    selSet <= 0;
    apb(1, REG_FIRST, 32'd1000);
    apb(1, REG_SECOND, 32'd2000);
    apb(1, REG_RATE12, 32'd100);
    apb(1, REG_RATE21, 32'd1000);
    apb(1, REG_CTRL, 32'h3);
    repeat (2100) @(posedge clk_sys);
    chk("set1", {8'h0, lim}, {8'h0, 12'd1000, 12'd1000});
    selSet <= 1;
    repeat (5000) @(posedge clk_sys);
    chk("ramp12", {31'h0, lim.fwd > 12'd1000 && lim.fwd < 12'd1700}, 32'h1);
    repeat (7000) @(posedge clk_sys);
    chk("top", {20'h0, lim.fwd}, 32'd2000);
    selSet <= 0;
    repeat (2100) @(posedge clk_sys);
    chk("ramp21", {20'h0, lim.fwd}, 32'd1000);
    selSet <= 1;
    repeat (2100) @(posedge clk_sys);
    apb(1, REG_SECOND, 32'd2000);
    repeat (1100) @(posedge clk_sys);
    chk("rewrite", {20'h0, lim.fwd}, 32'd2000);
    apb(1, REG_A2_OFFSET, 32'd100);
    fwdSet <= 16'd1500;
    apb(1, REG_CTRL, 32'h5);
    repeat (2100) @(posedge clk_sys);
    chk("offset", {8'h0, lim}, {8'h0, 12'd1400, 12'd1400});
    apb(1, REG_A2_TC, 32'h2);
    fwdSet <= 16'd2300;
    repeat (2100) @(posedge clk_sys);
    chk("lag", {31'h0, lim.fwd > 12'd1400 && lim.fwd < 12'd2200}, 32'h1);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire

// ==== tb/tls_far_side.sv ====
// tls_far_side: analog limit inputs and limit set pin model
`timescale 1ns/1ps
`default_nettype none
module tls_far_side (
  input  wire logic        clk_sys,
  input  wire logic [15:0] fwdSet,
  input  wire logic [15:0] revSet,
  input  wire logic        selSet,
  output logic      [15:0] fwdMv,
  output logic      [15:0] revMv,
  output logic             selPin
);
  always_ff @(posedge clk_sys) begin
    fwdMv  <= fwdSet;
    revMv  <= revSet;
    selPin <= selSet;
  end
endmodule // tls_far_side
`default_nettype wire
